// *** logic/lpmcs_top.sv ***
// Standby sequencer, main clock switch and warm-up counter with an AXI4-Lite register port.
// Assumes oscillator and time base clocks arrive as asynchronous pins sampled here.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module lpmcs_top #(
	parameter int P_SW_STOP_MAX = lpmcs_pkg::SW_STOP_MAX_CYC
) (
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_b,
	input  wire lpmcs_pkg::lpmcs_axi_req_type i_axi,
	output var  lpmcs_pkg::lpmcs_axi_rsp_type o_axi,
	input  wire logic                     i_high_clk,
	input  wire logic                     i_low_clk,
	input  wire logic [1:0]               i_tb_src,
	input  wire logic                     i_wdt_irq,
	output logic                          o_cpu_run,
	output logic                          o_main_clk_low,
	output logic                          o_main_clk_stop,
	output logic                          o_high_osc_en,
	output logic                          o_low_osc_en,
	output logic                          o_sysclk_reset,
	output logic                          o_tb_irq,
	output logic                          o_tb_service,
	output logic                          o_wuc_irq
);
	import lpmcs_pkg::*;

	function automatic logic mapped(input logic [7:0] a);
		return a inside {ADDR_SC2, ADDR_TBCTL, ADDR_IRQ, ADDR_WUCTL, ADDR_WUCMP, ADDR_STAT};
	endfunction

	// ==========================================================
	// Pin synchronisers
	// Bits: 0 high clock, 1 low clock, 3:2 time base sources.
	logic [3:0] s1_q, s2_q, s3_q, filt_q, filt_d, rise, fall;
	always_comb begin
		filt_d = (s2_q & s3_q) | (filt_q & ~(s2_q ^ s3_q));
		rise   = filt_d & ~filt_q;
		fall   = filt_q & ~filt_d;
	end
	// A high level counts only once the second and third stages agree, filtering high glitches; a low level counts as soon as they differ.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s1_q   <= 4'h0;
			s2_q   <= 4'h0;
			s3_q   <= 4'h0;
			filt_q <= 4'h0;
		end else begin
			s1_q   <= {i_tb_src, i_low_clk, i_high_clk};
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= filt_d;
		end
	end

	// ==========================================================
	// AXI4-Lite slave
	logic        awr_q, wr_q, bv_q, arr_q, rv_q, aw_have_q, w_have_q;
	logic [7:0]  aw_addr_q;
	logic [7:0]  wd_q;
	logic        ws0_q;
	logic [1:0]  bresp_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        wr_fire;
	logic [7:0]  sc2_q, tb_q, irq_q, wu_q, cmp_q, stat;
	assign wr_fire = aw_have_q & w_have_q & ~bv_q;
	assign o_axi   = '{awready: awr_q, wready: wr_q, bvalid: bv_q, bresp: bresp_q,
		arready: arr_q, rvalid: rv_q, rdata: rdata_q, rresp: rresp_q};
	function automatic logic wr_hit(input logic [7:0] off);
		return wr_fire && ws0_q && aw_addr_q == off;
	endfunction
	// Address and data are taken in either order; the answer follows both.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			awr_q <= 1'b1;
			wr_q <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			wd_q <= 8'h00;
			ws0_q <= 1'b0;
			bv_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (i_axi.awvalid && awr_q) begin
				awr_q <= 1'b0;
				aw_have_q <= 1'b1;
				aw_addr_q <= i_axi.awaddr;
			end
			if (i_axi.wvalid && wr_q) begin
				wr_q <= 1'b0;
				w_have_q <= 1'b1;
				wd_q <= i_axi.wdata[7:0];
				ws0_q <= i_axi.wstrb[0];
			end
			if (wr_fire) begin
				bv_q <= 1'b1;
				bresp_q <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
			end
			if (bv_q && i_axi.bready) begin
				bv_q <= 1'b0;
				awr_q <= 1'b1;
				wr_q <= 1'b1;
			end
		end
	end

	// Reads answer one cycle after the address is taken; unmapped reads give zero and an error.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			arr_q <= 1'b1;
			rv_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
		end else if (i_axi.arvalid && arr_q) begin
			arr_q <= 1'b0;
			rv_q <= 1'b1;
			rresp_q <= mapped(i_axi.araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (i_axi.araddr)
				ADDR_SC2:   rdata_q <= {24'h0, sc2_q};
				ADDR_TBCTL: rdata_q <= {24'h0, tb_q};
				ADDR_IRQ:   rdata_q <= {24'h0, irq_q};
				ADDR_WUCTL: rdata_q <= {24'h0, wu_q};
				ADDR_WUCMP: rdata_q <= {24'h0, cmp_q};
				ADDR_STAT:  rdata_q <= {24'h0, stat};
				default:    rdata_q <= 32'h0;
			endcase
		end else if (rv_q && i_axi.rready) begin
			rv_q <= 1'b0;
			arr_q <= 1'b1;
		end
	end

	// ==========================================================
	// Standby sequencer
	lpmcs_pwr_type pwr_q;
	lpmcs_clk_type clk_q;
	logic [7:0] warm_q;
	logic tb_edge, wake, halt_req, all_en;
	logic scrst_q;
	assign tb_edge  = fall[2 + int'(tb_q[TB_SRC])];
	assign wake     = pwr_q == PWR_HALT && tb_edge;
	assign halt_req = wr_hit(ADDR_SC2) && wd_q[SC2_HALT] && pwr_q == PWR_RUN;
	assign all_en   = irq_q[IRQ_IME] & irq_q[IRQ_TBIE] & tb_q[TB_EN];
	assign stat = {3'h0, scrst_q, pwr_q == PWR_HALT, clk_q == CLK_SLOW, o_wuc_irq, o_tb_irq};

	// Reset lands in a warm-up before the CPU runs again, whatever mode was active.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pwr_q <= PWR_WARM;
			warm_q <= 8'h00;
			o_cpu_run <= 1'b0;
		end else begin
			unique case (pwr_q)
				PWR_WARM: begin
					warm_q <= warm_q + 8'h01;
					if (warm_q == RST_WARM_CYC - 8'h01) begin
						pwr_q <= PWR_RUN;
						o_cpu_run <= 1'b1;
					end
				end
				PWR_RUN: if (halt_req && !i_wdt_irq) begin
					pwr_q <= PWR_HALT;
					o_cpu_run <= 1'b0;
				end
				PWR_HALT: if (wake) begin
					pwr_q <= PWR_RUN;
					o_cpu_run <= 1'b1;
				end
			endcase
		end
	end

	// Service is requested only when all three enables agree; otherwise the CPU simply resumes.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_tb_service <= 1'b0;
			o_tb_irq <= 1'b0;
		end else begin
			o_tb_service <= wake && all_en;
			if (wake && tb_q[TB_EN])
				o_tb_irq <= 1'b1;
			else if (wr_hit(ADDR_STAT) && wd_q[ST_TBI])
				o_tb_irq <= 1'b0;
		end
	end

	// Control registers; the halt bit is refused when a watchdog interrupt is pending.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sc2_q <= RST_SC2;
			tb_q <= 8'h00;
			irq_q <= 8'h00;
			wu_q <= 8'h00;
			cmp_q <= RST_WUCMP;
		end else begin
			if (wr_hit(ADDR_SC2)) begin
				sc2_q <= wd_q & SC2_MASK & ~8'(1 << SC2_HALT);
				sc2_q[SC2_HALT] <= halt_req && !i_wdt_irq;
			end else if (wake)
				sc2_q[SC2_HALT] <= 1'b0;
			if (wr_hit(ADDR_TBCTL))
				tb_q <= wd_q & 8'h09;
			if (wr_hit(ADDR_IRQ))
				irq_q <= wd_q & 8'h03;
			if (wr_hit(ADDR_WUCTL))
				wu_q <= wd_q & 8'h07;
			if (wr_hit(ADDR_WUCMP))
				cmp_q <= wd_q;
		end
	end
	assign o_high_osc_en = sc2_q[SC2_HIGHEN];
	assign o_low_osc_en  = sc2_q[SC2_LOWEN];

	// ==========================================================
	// Main clock switch
	logic [1:0]  qdiv_q;
	logic [3:0]  guard_q;
	logic [15:0] stop_cnt_q;
	logic        quarter;
	assign quarter = rise[1] && qdiv_q == 2'h3;
	// The gear clock is gated while waiting for a low/4 boundary, so no runt pulse escapes.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			clk_q <= CLK_FAST;
			qdiv_q <= 2'h0;
			o_main_clk_low <= 1'b0;
			o_main_clk_stop <= 1'b0;
		end else begin
			if (rise[1])
				qdiv_q <= qdiv_q + 2'h1;
			unique case (clk_q)
				CLK_FAST: if (sc2_q[SC2_SYSCLK] && sc2_q[SC2_LOWEN] && sc2_q[SC2_HIGHEN]) begin
					clk_q <= CLK_SYNC;
					o_main_clk_stop <= 1'b1;
				end
				CLK_SYNC: if (quarter) begin
					clk_q <= CLK_SLOW;
					o_main_clk_low <= 1'b1;
					o_main_clk_stop <= 1'b0;
				end
				CLK_SLOW: if (!sc2_q[SC2_SYSCLK]) begin
					clk_q <= CLK_FAST;
					o_main_clk_low <= 1'b0;
				end
			endcase
		end
	end

	// Stopping the high oscillator too soon after a select change corrupts the clock tree.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			guard_q <= 4'h0;
			o_sysclk_reset <= 1'b0;
			scrst_q <= 1'b0;
		end else begin
			o_sysclk_reset <= 1'b0;
			if (wr_hit(ADDR_SC2) && wd_q[SC2_SYSCLK] != sc2_q[SC2_SYSCLK])
				guard_q <= GUARD_CYC;
			else if (guard_q != 4'h0)
				guard_q <= guard_q - 4'h1;
			if (wr_hit(ADDR_SC2) && guard_q != 4'h0 && sc2_q[SC2_HIGHEN] && !wd_q[SC2_HIGHEN]) begin
				o_sysclk_reset <= 1'b1;
				scrst_q <= 1'b1;
			end else if (wr_hit(ADDR_STAT) && wd_q[ST_SCRST])
				scrst_q <= 1'b0;
		end
	end

	// Helper count of gated cycles, read only by the bound check below.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			stop_cnt_q <= 16'h0;
		else
			stop_cnt_q <= o_main_clk_stop ? stop_cnt_q + 16'h1 : 16'h0;
	end

	// ==========================================================
	// Warm-up counter
	logic       wu_run_q;
	logic [7:0] wu_cnt_q;
	logic [2:0] pre_q;
	logic       src_edge, wu_start;
	assign src_edge = wu_q[WU_SRC] ? rise[1] : rise[0];
	assign wu_start = wr_hit(ADDR_SC2) && ((wd_q[SC2_LOWEN] && !sc2_q[SC2_LOWEN]) ||
		(wd_q[SC2_HIGHEN] && !sc2_q[SC2_HIGHEN]));
	// Divide by 2^n on the prescaler; a divider field of 00 passes every edge.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wu_run_q <= 1'b0;
			wu_cnt_q <= 8'h00;
			pre_q <= 3'h0;
			o_wuc_irq <= 1'b0;
		end else begin
			if (wu_start) begin
				wu_run_q <= 1'b1;
				wu_cnt_q <= 8'h00;
				pre_q <= 3'h0;
			end else if (wu_run_q && wu_cnt_q == cmp_q) begin
				wu_run_q <= 1'b0;
			end else if (wu_run_q && src_edge) begin
				pre_q <= pre_q + 3'h1;
				if ((pre_q & 3'((1 << wu_q[WU_DIV +: 2]) - 1)) == 3'((1 << wu_q[WU_DIV +: 2]) - 1))
					wu_cnt_q <= wu_cnt_q + 8'h01;
			end
			if (wu_run_q && !wu_start && wu_cnt_q == cmp_q)
				o_wuc_irq <= 1'b1;
			else if (wr_hit(ADDR_STAT) && wd_q[ST_WUI])
				o_wuc_irq <= 1'b0;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	sequence s_halt_write;
		halt_req && !i_wdt_irq;
	endsequence
	sequence s_wake;
		pwr_q == PWR_HALT && tb_edge;
	endsequence
	halt_entry_a: assert property (s_halt_write |=> pwr_q == PWR_HALT && !o_cpu_run)
		else $error("halt write did not enter deep idle");
	wdt_block_a: assert property (halt_req && i_wdt_irq
		|=> pwr_q == PWR_RUN && !sc2_q[SC2_HALT]) else $error("halt taken despite watchdog");
	wake_clear_a: assert property (s_wake |=> !sc2_q[SC2_HALT] && o_cpu_run)
		else $error("wake did not clear halt bit");
	wake_latch_a: assert property (s_wake ##0 tb_q[TB_EN] |=> o_tb_irq)
		else $error("time base latch not set on wake");
	service_a: assert property (o_tb_service |-> $past(pwr_q == PWR_HALT && all_en))
		else $error("service pulse without full enable wake");
	quiet_wake_a: assert property (s_wake ##0 irq_q[1:0] == 2'h0 |=> !o_tb_service)
		else $error("service requested with enables clear");
	switch_done_a: assert property (clk_q == CLK_SYNC && quarter
		|=> o_main_clk_low ##0 !o_main_clk_stop) else $error("switch to low clock not completed");
	stop_bound_a: assert property (stop_cnt_q <= 16'(P_SW_STOP_MAX))
		else $error("main clock stopped too long");
	guard_rst_a: assert property (wr_hit(ADDR_SC2) && guard_q != 4'h0
		&& sc2_q[SC2_HIGHEN] && !wd_q[SC2_HIGHEN] |=> o_sysclk_reset ##1 !o_sysclk_reset)
		else $error("early oscillator stop missed clock reset");
	wu_done_a: assert property (wu_run_q && !wu_start && wu_cnt_q == cmp_q
		|=> o_wuc_irq && !wu_run_q) else $error("warm-up compare missed");
endmodule // lpmcs_top
`default_nettype wire

// *** pkg/lpmcs_pkg.sv ***
// Constants, field layout and carrier types for the low-power and clock switch block.
// Assumes a 25 MHz system clock and an AXI4-Lite master with 8-bit byte addresses.
package lpmcs_pkg;
	// ==========================================================
	// Register map (byte addresses) and field positions
	localparam logic [7:0] ADDR_SC2   = 8'h00;
	localparam logic [7:0] ADDR_TBCTL = 8'h04;
	localparam logic [7:0] ADDR_IRQ   = 8'h08;
	localparam logic [7:0] ADDR_WUCTL = 8'h0c;
	localparam logic [7:0] ADDR_WUCMP = 8'h10;
	localparam logic [7:0] ADDR_STAT  = 8'h14;
	localparam int SC2_HALT   = 2;
	localparam int SC2_SYSCLK = 4;
	localparam int SC2_LOWEN  = 5;
	localparam int SC2_HIGHEN = 6;
	localparam logic [7:0] SC2_MASK = 8'h74;
	localparam int TB_SRC     = 0;
	localparam int TB_EN      = 3;
	localparam int IRQ_IME    = 0;
	localparam int IRQ_TBIE   = 1;
	localparam int WU_SRC     = 0;
	localparam int WU_DIV     = 1;
	localparam int ST_TBI     = 0;
	localparam int ST_WUI     = 1;
	localparam int ST_SLOW    = 2;
	localparam int ST_HALT    = 3;
	localparam int ST_SCRST   = 4;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_SC2   = 8'h40;
	localparam logic [7:0] RST_WUCMP = 8'hff;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// Timing
	localparam longint CLK_HZ = 25000000;
	localparam longint LOW_HZ = 32768;
	localparam longint SW_STOP_MAX_LOWPER = 10;
	localparam int SW_STOP_MAX_CYC = int'((SW_STOP_MAX_LOWPER * CLK_HZ) / LOW_HZ);
	localparam int MC_CLKS   = 4;
	localparam int GUARD_MC  = 2;
	localparam logic [3:0] GUARD_CYC = 4'(MC_CLKS * GUARD_MC);
	localparam logic [7:0] RST_WARM_CYC = 8'h40;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {PWR_WARM, PWR_RUN, PWR_HALT} lpmcs_pwr_type;
	typedef enum logic [1:0] {CLK_FAST, CLK_SYNC, CLK_SLOW} lpmcs_clk_type;
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} lpmcs_axi_req_type;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} lpmcs_axi_rsp_type;
endpackage

// *** verif/tb_lpmcs_top.sv ***
// Self-checking bench for the standby sequencer, clock switch and warm-up counter.
// Assumes lpmcs_pkg is compiled first and the design top is lpmcs_top.
`timescale 1ns/100ps
`default_nettype none
module tb_lpmcs_top;
	import lpmcs_pkg::*;
	localparam int LOW_PER = 40;
	localparam int P_STOP  = 10 * LOW_PER;
	logic              i_clk    = 1'b0;
	logic              i_rst_b  = 1'b0;
	lpmcs_axi_req_type axi_q    = '0;
	lpmcs_axi_rsp_type rsp;
	logic              high_clk = 1'b0;
	logic              low_clk  = 1'b0;
	logic [1:0]        tb_src   = 2'b11;
	logic              wdt      = 1'b0;
	logic              cpu_run, clk_low, clk_stop, hi_en, lo_en, sc_rst, tb_irq, tb_svc, wuc_irq;
	int                miscompares     = 0;
	int                samples_checked = 0;
	int                low_rises       = 0;
	int                svc_cnt         = 0;
	int                rst_cnt         = 0;
	int                div_cnt         = 0;

	// A small low clock period keeps the switch short; the stop bound is scaled with it.
	lpmcs_top #(.P_SW_STOP_MAX(P_STOP)) u_lpmcs_top (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_axi(axi_q), .o_axi(rsp),
		.i_high_clk(high_clk), .i_low_clk(low_clk), .i_tb_src(tb_src), .i_wdt_irq(wdt),
		.o_cpu_run(cpu_run), .o_main_clk_low(clk_low), .o_main_clk_stop(clk_stop),
		.o_high_osc_en(hi_en), .o_low_osc_en(lo_en), .o_sysclk_reset(sc_rst),
		.o_tb_irq(tb_irq), .o_tb_service(tb_svc), .o_wuc_irq(wuc_irq));

	// The system clock toggles every half period.
	always #20 i_clk = ~i_clk;

	// Oscillator pins step on the rising edge and only oscillate while enabled.
	// One-cycle pulses are counted here.
	always @(posedge i_clk) begin
		div_cnt <= (div_cnt == LOW_PER - 1) ? 0 : div_cnt + 1;
		if (div_cnt == LOW_PER / 2 - 1 && lo_en === 1'b1) low_clk <= 1'b1;
		if (div_cnt == LOW_PER / 2 - 1 && lo_en === 1'b1) low_rises <= low_rises + 1;
		if (div_cnt == LOW_PER - 1) low_clk <= 1'b0;
		if (div_cnt % 3 == 0 && hi_en === 1'b1) high_clk <= ~high_clk;
		if (tb_svc === 1'b1) svc_cnt <= svc_cnt + 1;
		if (sc_rst === 1'b1) rst_cnt <= rst_cnt + 1;
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_end(input string s);
		$display("Test %s finished", s);
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Write with address and data offered together; each is dropped once taken.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
		int n;
		n = 0;
		@(posedge i_clk);
		axi_q.awvalid <= 1'b1;
		axi_q.awaddr  <= a;
		axi_q.wvalid  <= 1'b1;
		axi_q.wdata   <= {24'($urandom()), d};
		axi_q.wstrb   <= 4'hf;
		axi_q.bready  <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (axi_q.awvalid && rsp.awready) axi_q.awvalid <= 1'b0;
			if (axi_q.wvalid && rsp.wready) axi_q.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1 && n < 50);
		axi_q.bready <= 1'b0;
		check(rsp.bvalid, 1'b1);
		check(rsp.bresp, resp);
	endtask

	// Read one register and compare the whole word, upper bits included.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] resp);
		int n;
		n = 0;
		@(posedge i_clk);
		axi_q.araddr  <= a;
		axi_q.arvalid <= 1'b1;
		axi_q.rready  <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
			if (axi_q.arvalid && rsp.arready) axi_q.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1 && n < 50);
		axi_q.rready <= 1'b0;
		check(rsp.rvalid, 1'b1);
		check(rsp.rresp, resp);
		check(rsp.rdata, {24'h0, exp});
	endtask

	// Bounded wait on one output; the count tells how long it took.
	task automatic wait_for(input int sel, input int maxc, output int n);
		n = 0;
		while (!((sel == 0 && cpu_run === 1'b1) || (sel == 1 && wuc_irq === 1'b1) ||
				(sel == 2 && clk_stop === 1'b1) || (sel == 3 && clk_low === 1'b1)) && n < maxc) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		check(n < maxc, 1'b1);
	endtask

	// A watchdog ends a hung run well past the few thousand cycles the tests need.
	initial begin
		#(40 * 20000);
		miscompares++;
		tally_and_finish();
	end

	// ==========================================================
	// Main sequence
	initial begin
		int n, s0, cmp, e;
		logic [2:0] en;
		logic       sel;
		logic [2:0] combos [4];
		combos = '{3'b000, 3'b111, 3'b001, 3'b110};
		void'($urandom(32'h571a1d59));
		repeat (2) @(posedge i_clk);
		check(hi_en, 1'b1);
		i_rst_b <= 1'b1;
		wait_for(0, 100, n);
		check(n >= 62 && n <= 66, 1'b1);
		rd(ADDR_SC2, RST_SC2, RESP_OKAY);
		rd(ADDR_WUCMP, RST_WUCMP, RESP_OKAY);
		wr(8'h40, 8'hff, RESP_SLVERR);
		rd(8'h40, 8'h00, RESP_SLVERR);
		test_end("registers");
		// Four enable combinations: a halt, a stray edge on the other source, then the wake edge.
		for (int i = 0; i < 4; i++) begin
			en = combos[i];
			sel = 1'($urandom());
			wr(ADDR_IRQ, {6'h0, en[1], en[2]}, RESP_OKAY);
			wr(ADDR_TBCTL, {4'h0, en[0], 2'b00, sel}, RESP_OKAY);
			s0 = svc_cnt;
			wr(ADDR_SC2, 8'h44, RESP_OKAY);
			repeat (3) @(posedge i_clk);
			#1 check(cpu_run, 1'b0);
			@(posedge i_clk);
			tb_src[~sel] <= 1'b0;
			repeat (12) @(posedge i_clk);
			#1 check(cpu_run, 1'b0);
			@(posedge i_clk);
			tb_src[sel] <= 1'b0;
			wait_for(0, 20, n);
			check(n <= 8, 1'b1);
			repeat (2) @(posedge i_clk);
			#1 check(svc_cnt - s0, (en == 3'b111) ? 1 : 0);
			check(tb_irq, en[0]);
			rd(ADDR_SC2, 8'h40, RESP_OKAY);
			wr(ADDR_STAT, 8'h01, RESP_OKAY);
			rd(ADDR_STAT, 8'h00, RESP_OKAY);
			tb_src <= 2'b11;
		end
		test_end("halt and wake");
		wdt <= 1'b1;
		wr(ADDR_SC2, 8'h44, RESP_OKAY);
		repeat (4) @(posedge i_clk);
		#1 check(cpu_run, 1'b1);
		rd(ADDR_SC2, 8'h40, RESP_OKAY);
		wdt <= 1'b0;
		// A reset in mid-halt must end the halt and run the warm-up again.
		wr(ADDR_SC2, 8'h44, RESP_OKAY);
		repeat (3) @(posedge i_clk);
		#1 check(cpu_run, 1'b0);
		@(posedge i_clk);
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_b <= 1'b1;
		wait_for(0, 100, n);
		check(n >= 62 && n <= 66, 1'b1);
		rd(ADDR_SC2, RST_SC2, RESP_OKAY);
		test_end("watchdog and reset");
		// The prescaler is cleared on start, but the edge count is still allowed to run over by one divided step.
		for (int d = 0; d < 4; d++) begin
			cmp = 2 + ($urandom() % 4);
			e = cmp * (1 << d);
			wr(ADDR_WUCTL, {5'h0, 2'(d), 1'b1}, RESP_OKAY);
			wr(ADDR_WUCMP, 8'(cmp), RESP_OKAY);
			wr(ADDR_SC2, 8'h60, RESP_OKAY);
			s0 = low_rises;
			check(lo_en, 1'b1);
			wait_for(1, e * LOW_PER + 200, n);
			check(low_rises - s0 >= e - 1 && low_rises - s0 <= e + (1 << d) + 1, 1'b1);
			rd(ADDR_STAT, 8'h02, RESP_OKAY);
			wr(ADDR_STAT, 8'h02, RESP_OKAY);
			wr(ADDR_SC2, 8'h40, RESP_OKAY);
		end
		// With the high clock as source two counts end long before two low-clock periods.
		wr(ADDR_WUCTL, 8'h00, RESP_OKAY);
		wr(ADDR_WUCMP, 8'h02, RESP_OKAY);
		wr(ADDR_SC2, 8'h60, RESP_OKAY);
		wait_for(1, 60, n);
		check(n <= 30, 1'b1);
		wr(ADDR_STAT, 8'h02, RESP_OKAY);
		wr(ADDR_SC2, 8'h40, RESP_OKAY);
		test_end("warm-up");
		wr(ADDR_SC2, 8'h60, RESP_OKAY);
		s0 = rst_cnt;
		wr(ADDR_SC2, 8'h70, RESP_OKAY);
		wait_for(2, 8, n);
		wait_for(3, P_STOP + 20, n);
		check(n <= P_STOP, 1'b1);
		check(clk_stop, 1'b0);
		check(clk_low, 1'b1);
		repeat (GUARD_CYC + 4) @(posedge i_clk);
		wr(ADDR_SC2, 8'h30, RESP_OKAY);
		repeat (2) @(posedge i_clk);
		#1 check(rst_cnt - s0, 0);
		check(hi_en, 1'b0);
		wr(ADDR_SC2, 8'h60, RESP_OKAY);
		repeat (2) @(posedge i_clk);
		#1 check(clk_low, 1'b0);
		wr(ADDR_SC2, 8'h70, RESP_OKAY);
		wr(ADDR_SC2, 8'h30, RESP_OKAY);
		repeat (3) @(posedge i_clk);
		#1 check(rst_cnt - s0, 1);
		test_end("clock switch");
		tally_and_finish();
	end
endmodule // tb_lpmcs_top
`default_nettype wire
